// *** verilog/phase_cfg_defs.vh ***
// Constants for the phase two and phase three configuration register bank
`ifndef PHASE_CFG_DEFS_VH
`define PHASE_CFG_DEFS_VH

// Register word indices and byte addresses (index times four)
`define PHASE2_CONFIG_IDX 8'h30
`define PHASE3_CONFIG_IDX 8'h31
`define RAMPDOWN_CTRL_ADDR 12'h0c8
`define PHASE2_STATUS_ADDR 12'h0cc
`define PHASE3_STATUS_ADDR 12'h0d0

// Reset values
`define PHASE_CONFIG_RST 8'hd1
`define RAMPDOWN_CTRL_RST 2'h0

// Field positions inside a phase configuration byte
`define CFG_DISCHARGE_BIT 7
`define CFG_ILIM_HI 6
`define CFG_ILIM_LO 4
`define CFG_RSVD_HI 3
`define CFG_RSVD_LO 2
`define CFG_FPWM_BIT 1
`define CFG_FSLEW_BIT 0

// Hold time after reaching target, in ns, and the clock period in ns
`define FPWM_HOLD_NS 50000
`define PCLK_PERIOD_NS 100
`define FPWM_HOLD_CYCLES (`FPWM_HOLD_NS / `PCLK_PERIOD_NS)
`define HOLD_CNT_W 10

// Phase sequencer states
`define PH_IDLE 2'h0
`define PH_RAMP 2'h1
`define PH_HOLD 2'h2

`endif

// *** verilog/phase_mode_ctrl.v ***
// Per-phase mode control: skip or forced PWM, with ramp-down hold
`include "phase_cfg_defs.vh"

module phase_mode_ctrl (
  input wire pclk,
  input wire presetn,
  input wire [7:0] config_byte,
  input wire ramp_down,
  input wire at_target,
  output reg forced_pwm_on,
  output reg neg_current_block,
  output reg holding
);

  localparam [1:0] ST_IDLE = `PH_IDLE;
  localparam [1:0] ST_RAMP = `PH_RAMP;
  localparam [1:0] ST_HOLD = `PH_HOLD;
  localparam integer HOLD_LAST_I = `FPWM_HOLD_CYCLES - 1;
  localparam [`HOLD_CNT_W-1:0] HOLD_LAST = HOLD_LAST_I[`HOLD_CNT_W-1:0];

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`HOLD_CNT_W-1:0] cnt_q;
  reg [`HOLD_CNT_W-1:0] cnt_d;
  wire fpwm_bit;
  wire fslew_bit;
  wire fpwm_mode;

  assign fpwm_bit = config_byte[`CFG_FPWM_BIT];
  assign fslew_bit = config_byte[`CFG_FSLEW_BIT];

  // Sequencer for forced PWM during ramp-down and the hold after it
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (ramp_down && fslew_bit) begin
          state_d = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (at_target || !ramp_down) begin
          state_d = ST_HOLD;
          cnt_d = {`HOLD_CNT_W{1'b0}};
        end
      end
      ST_HOLD: begin
        if (ramp_down && fslew_bit && !at_target) begin
          state_d = ST_RAMP;
        end else if (cnt_q == HOLD_LAST) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Forced PWM when selected, or while sequencer is active
  assign fpwm_mode = fpwm_bit || (state_d != ST_IDLE);

  // Sequencer state and registered mode outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q <= {`HOLD_CNT_W{1'b0}};
      forced_pwm_on <= 1'b0;
      neg_current_block <= 1'b1;
      holding <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      forced_pwm_on <= fpwm_mode;
      neg_current_block <= !fpwm_mode;
      holding <= (state_d == ST_HOLD);
    end
  end

endmodule // phase_mode_ctrl

// *** verilog/buck_phase_config_regs.v ***
// APB register bank and mode control for converter phases two and three
// Notes on behaviour
// - Bits 6:4 select one of eight ascending current limits; default 101.
// - Forced-PWM bit 0 gives automatic skip; 1 gives forced PWM.
// - Slew control off and forced PWM off: skip mode during ramp-down.
// - In skip mode negative low-side current is blocked.
// - Slew control on: forced PWM during ramp-down, sinking output current.
// - After such a ramp-down, forced PWM holds 50 us past target.
// - Skip ramp-down under heavy load is still capped by slew select.
// - Phase three register at 0x31, read/write, resets to 0xd1.
// - Phase two register at 0x30, same layout, resets to 0xd1.
`include "phase_cfg_defs.vh"

// Register map, one aligned word per register, data in bits 7:0
//   0x0c0  phase two configuration, read/write, resets to 0xd1
//   0x0c4  phase three configuration, read/write, resets to 0xd1
//   0x0c8  shared ramp-down slew select, bits 1:0, resets to 0
//   0x0cc  phase two status, read only
//   0x0d0  phase three status, read only
// Any other address answers with an error and reads as zero
//
// Configuration byte layout
//   bit 7    output active discharge enable
//   bits 6:4 current-limit code, eight ascending steps
//   bits 3:2 reserved, always stored as zero
//   bit 1    forced PWM select, 0 leaves automatic skip
//   bit 0    falling slew control for ramp-down
//
// Status word layout
//   bit 0    forced PWM engaged
//   bit 1    negative low-side current blocked
//   bit 2    post-target hold running
//
// Bus timing
//   No wait states: pready is tied high
//   Read data captured at the setup edge, stands in the access phase
//   Writes land at the access edge when byte lane 0 is enabled
//   A write with lane 0 disabled is dropped without an error
//   Upper read bits are always zero
//
// Mode behaviour per phase
//   Forced PWM select wins over everything else
//   Slew control on plus ramp-down engages forced PWM
//   Reaching target, or ramp-down ending, starts a fixed hold
//   The hold keeps forced PWM for 500 clock cycles, then releases
//   A new ramp-down during the hold re-enters the ramp state
//   Negative-current block is always the inverse of forced PWM
//   Mode outputs are registered, one cycle after their inputs
//
// Hazards and limits
//   Hold length assumes the 100 ns clock; a faster clock shortens it
//   Ramp and target inputs are taken as synchronous to pclk
//   The slew cap is a plain copy; the analog side applies it
//   Status reads are snapshots taken at the setup edge
//   Reset is asynchronous; outputs go to their safe skip state

module buck_phase_config_regs (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave side
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // Analog phase status inputs
  input wire phase2_ramp_down,
  input wire phase2_at_target,
  input wire phase3_ramp_down,
  input wire phase3_at_target,
  // Field and mode outputs toward the analog phases
  output wire phase2_active_discharge,
  output wire phase3_active_discharge,
  output wire [2:0] phase2_current_limit_code,
  output wire [2:0] phase3_current_limit_code,
  output wire [7:0] phase2_ilim_step,
  output wire [7:0] phase3_ilim_step,
  output wire [1:0] phase2_slew_cap,
  output wire [1:0] phase3_slew_cap,
  output wire phase2_forced_pwm_on,
  output wire phase3_forced_pwm_on,
  output wire phase2_neg_current_block,
  output wire phase3_neg_current_block
);

  localparam [11:0] PHASE2_ADDR = {2'h0, `PHASE2_CONFIG_IDX, 2'h0};
  localparam [11:0] PHASE3_ADDR = {2'h0, `PHASE3_CONFIG_IDX, 2'h0};

  reg [7:0] cfg_q [0:1];
  reg [1:0] rampdown_slew_select_q;
  wire [1:0] fpwm_on;
  wire [1:0] nblock;
  wire [1:0] hold;
  wire [1:0] ramp_in;
  wire [1:0] target_in;
  wire wr_en;
  wire wr_slew;
  wire rd_en;
  wire addr_ok;
  wire [11:0] phase_addr [0:1];

  // One-hot step for a current-limit code
  function [7:0] ilim_step;
    input [2:0] code;
    begin
      ilim_step = 8'h01 << code;
    end
  endfunction

  // Address lookup used by the handshake decode; the read mux compares addresses itself
  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == PHASE2_ADDR) || (a == PHASE3_ADDR) ||
        (a == `RAMPDOWN_CTRL_ADDR) || (a == `PHASE2_STATUS_ADDR) ||
        (a == `PHASE3_STATUS_ADDR);
    end
  endfunction

  // APB handshake: zero wait states, error on unmapped address
  assign addr_ok = is_mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;
  // Write strobe for the shared slew select, lane 0 only
  assign wr_slew = wr_en && pstrb[0] && (paddr == `RAMPDOWN_CTRL_ADDR);
  assign phase_addr[0] = PHASE2_ADDR;
  assign phase_addr[1] = PHASE3_ADDR;
  assign ramp_in = {phase3_ramp_down, phase2_ramp_down};
  assign target_in = {phase3_at_target, phase2_at_target};

  // Per-phase configuration storage and mode control
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_phase
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg_q[g] <= `PHASE_CONFIG_RST;
        end else if (wr_en && pstrb[0] && paddr == phase_addr[g]) begin
          cfg_q[g] <= {pwdata[`CFG_DISCHARGE_BIT:`CFG_ILIM_LO], 2'h0,
            pwdata[`CFG_FPWM_BIT:`CFG_FSLEW_BIT]};
        end
      end

      phase_mode_ctrl u_mode (
        .pclk(pclk),
        .presetn(presetn),
        .config_byte(cfg_q[g]),
        .ramp_down(ramp_in[g]),
        .at_target(target_in[g]),
        .forced_pwm_on(fpwm_on[g]),
        .neg_current_block(nblock[g]),
        .holding(hold[g])
      );
    end
  endgenerate

  // Shared ramp-down slew select
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rampdown_slew_select_q <= `RAMPDOWN_CTRL_RST;
    end else if (wr_slew) begin
      rampdown_slew_select_q <= pwdata[1:0];
    end
  end

  // Read data registered in the setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      if (paddr == PHASE2_ADDR) begin
        prdata <= {24'h00_0000, cfg_q[0]};
      end else if (paddr == PHASE3_ADDR) begin
        prdata <= {24'h00_0000, cfg_q[1]};
      end else if (paddr == `RAMPDOWN_CTRL_ADDR) begin
        prdata <= {30'h0000_0000, rampdown_slew_select_q};
      end else if (paddr == `PHASE2_STATUS_ADDR) begin
        prdata <= {29'h0000_0000, hold[0], nblock[0], fpwm_on[0]};
      end else if (paddr == `PHASE3_STATUS_ADDR) begin
        prdata <= {29'h0000_0000, hold[1], nblock[1], fpwm_on[1]};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Field outputs toward the analog phases
  assign phase2_active_discharge = cfg_q[0][`CFG_DISCHARGE_BIT];
  assign phase3_active_discharge = cfg_q[1][`CFG_DISCHARGE_BIT];
  assign phase2_current_limit_code = cfg_q[0][`CFG_ILIM_HI:`CFG_ILIM_LO];
  assign phase3_current_limit_code = cfg_q[1][`CFG_ILIM_HI:`CFG_ILIM_LO];
  assign phase2_ilim_step = ilim_step(cfg_q[0][`CFG_ILIM_HI:`CFG_ILIM_LO]);
  assign phase3_ilim_step = ilim_step(cfg_q[1][`CFG_ILIM_HI:`CFG_ILIM_LO]);
  // Slew cap applies in every ramp-down mode
  assign phase2_slew_cap = rampdown_slew_select_q;
  assign phase3_slew_cap = rampdown_slew_select_q;
  assign phase2_forced_pwm_on = fpwm_on[0];
  assign phase3_forced_pwm_on = fpwm_on[1];
  assign phase2_neg_current_block = nblock[0];
  assign phase3_neg_current_block = nblock[1];

endmodule // buck_phase_config_regs

// *** tb/buck_phase_config_regs_monitor.sv ***
// Port assertions for the phase configuration register bank
module buck_phase_config_regs_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire pslverr,
  input wire [31:0] prdata,
  input wire phase3_ramp_down,
  input wire phase3_at_target,
  input wire phase2_active_discharge,
  input wire [2:0] phase2_current_limit_code,
  input wire [2:0] phase3_current_limit_code,
  input wire [7:0] phase2_ilim_step,
  input wire [7:0] phase3_ilim_step,
  input wire phase2_forced_pwm_on,
  input wire phase3_forced_pwm_on,
  input wire phase2_neg_current_block,
  input wire phase3_neg_current_block
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase and target arrival
  sequence access_s; psel && penable; endsequence
  sequence target_s; phase3_forced_pwm_on && $rose(phase3_at_target) && !phase3_ramp_down; endsequence
  neg_inverse_a: assert property (phase2_neg_current_block == !phase2_forced_pwm_on && phase3_neg_current_block == !phase3_forced_pwm_on) else $error("block not inverse");
  ilim_onehot_a: assert property (phase2_ilim_step == 8'h01 << phase2_current_limit_code && phase3_ilim_step == 8'h01 << phase3_current_limit_code) else $error("step mismatch");
  unmapped_err_a: assert property (access_s ##0 (paddr < 12'h0c0 || paddr > 12'h0d0 || paddr[1:0] != 2'h0) |-> pslverr) else $error("no error");
  mapped_ok_a: assert property (access_s ##0 (paddr == 12'h0c0 || paddr == 12'h0c4) |-> !pslverr) else $error("false error");
  upper_zero_a: assert property (access_s ##0 !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
  rsvd_zero_a: assert property (access_s ##0 !pwrite && !pslverr && paddr < 12'h0c8 |-> prdata[3:2] == 2'h0) else $error("reserved set");
  reset_dflt_a: assert property ($rose(presetn) |-> phase2_active_discharge && phase2_current_limit_code == 3'h5 && phase3_current_limit_code == 3'h5) else $error("bad default");
  hold_keep_a: assert property (target_s |=> phase3_forced_pwm_on [*8]) else $error("hold too short");
endmodule // buck_phase_config_regs_monitor
bind buck_phase_config_regs buck_phase_config_regs_monitor u_mon (.*);

// *** tb/buck_phase_config_regs_test.sv ***
// Register and mode tests for the phase configuration bank
`include "phase_cfg_defs.vh"
module buck_phase_config_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] a2 = {`PHASE2_CONFIG_IDX, 2'h0};
  localparam logic [11:0] a3 = {`PHASE3_CONFIG_IDX, 2'h0};
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
  logic phase2_ramp_down = 1'h0, phase2_at_target = 1'h0;
  logic phase3_ramp_down = 1'h0, phase3_at_target = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0] pstrb = 4'hf;
  wire pready, pslverr, phase2_active_discharge, phase3_active_discharge;
  wire phase2_forced_pwm_on, phase3_forced_pwm_on, phase2_neg_current_block, phase3_neg_current_block;
  wire [31:0] prdata;
  wire [2:0] phase2_current_limit_code, phase3_current_limit_code;
  wire [7:0] phase2_ilim_step, phase3_ilim_step;
  wire [1:0] phase2_slew_cap, phase3_slew_cap;
  int mismatches = 0, compares = 0, cycles = 0, n;
  buck_phase_config_regs u_dut (.*);
  // Clock and hang limit
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  // Compare one value
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, driven right after a rising edge, released at the answer edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Verdict and end of run
  task test_done;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, a2, 32'h0);
    check("phase2_config", rd, 32'hd1);
    apb(1'h0, a3, 32'h0);
    check("phase3_config", rd, 32'hd1);
    check("phase3_discharge", phase3_active_discharge, 32'h1);
    apb(1'h1, a3, 32'hff);
    apb(1'h0, a3, 32'h0);
    check("phase3_config", rd, 32'hf3);
    check("phase3_mode", {phase3_neg_current_block, phase3_forced_pwm_on}, 32'h1);
    for (int k = 0; k < 8; k++) begin
      apb(1'h1, a2, 32'(k << 4));
      @(negedge pclk);
      check("phase2_ilim_step", phase2_ilim_step, 32'h1 << k);
      check("phase2_code", phase2_current_limit_code, 32'(k));
    end
    apb(1'h1, `RAMPDOWN_CTRL_ADDR, 32'h2);
    @(negedge pclk);
    check("slew_cap", {phase2_slew_cap, phase3_slew_cap}, 32'ha);
    apb(1'h0, 12'h0fc, 32'h0);
    check("pslverr", err, 32'h1);
    check("prdata", rd, 32'h0);
    apb(1'h1, a2, 32'h52);
    repeat (2) @(negedge pclk);
    check("phase2_mode", {phase2_neg_current_block, phase2_forced_pwm_on}, 32'h1);
    apb(1'h1, a2, 32'h50);
    @(posedge pclk);
    phase2_ramp_down <= 1'h1;
    repeat (3) @(negedge pclk);
    check("phase2_mode", {phase2_neg_current_block, phase2_forced_pwm_on}, 32'h2);
    @(posedge pclk);
    phase2_ramp_down <= 1'h0;
    phase2_at_target <= 1'h1;
    apb(1'h0, `PHASE2_STATUS_ADDR, 32'h0);
    check("phase2_status", rd, 32'h2);
    apb(1'h1, a3, 32'hd1);
    @(posedge pclk);
    phase3_ramp_down <= 1'h1;
    repeat (3) @(negedge pclk);
    check("phase3_mode", {phase3_neg_current_block, phase3_forced_pwm_on}, 32'h1);
    @(posedge pclk);
    phase3_ramp_down <= 1'h0;
    phase3_at_target <= 1'h1;
    n = 0;
    while (phase3_forced_pwm_on !== 1'h0 && n < 600) begin
      @(negedge pclk);
      n++;
    end
    check("hold_span", 32'(n >= 499 && n <= 504), 32'h1);
    test_done();
  end
endmodule // buck_phase_config_regs_test
